// File: logic/sram_port_pkg.sv
// Shared constants and types of the burst SRAM port logic
package sram_port_pkg;
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int BURST = 4;
  localparam int ADDR_W = 18;
  // Beat counts from the positive rise that takes the request to the edge of the first beat
  localparam int RD_LAT_PLL = 5;
  localparam int RD_LAT_LEGACY = 3;
  localparam int WR_LAT = 2;
  localparam int LINE_D = 8;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    OP_NONE = 3'b001,
    OP_READ = 3'b010,
    OP_WRITE = 3'b100
  } op_t;

  localparam op_t OP_RST = OP_NONE;
  localparam logic [1:0] PLL_SYNC_RST = 2'h3;
  localparam logic PHASE_RST = 1'h0;
endpackage

// File: logic/fifo_stream_if.sv
// Valid/ready stream between the port logic and its write FIFO
`timescale 1ns/1ps
`default_nettype none
interface fifo_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface
`default_nettype wire

// File: logic/write_fifo.sv
// Synchronous FIFO that buffers captured write beats ahead of the array
`timescale 1ns/1ps
`default_nettype none
module write_fifo #(
  parameter int W = 8,
  parameter int DEPTH = sram_port_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  fifo_stream_if.snk in_s,
  fifo_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;

  fifo_st_t s_r;
  fifo_st_t s_nxt;
  logic [W-1:0] mem [0:DEPTH-1];
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad_shape
    $error("write_fifo depth must be a power of two of at least 2");
  end

  assign in_s.ready = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_s.valid = (s_r.cnt != '0);
  assign out_s.data = mem[s_r.rp];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_r.wp] <= in_s.data;
    end
  end
endmodule
`default_nettype wire

// File: logic/burst_sram_port.sv
// Command, burst and byte-write logic of a two-port double-data-rate burst SRAM
`timescale 1ns/1ps
`default_nettype none
module burst_sram_port #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W,
  parameter int FIFO_DEPTH = sram_port_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_run,
  input wire logic pll_disable_n,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [sram_port_pkg::DATA_W-1:0] wr_data,
  input wire logic [sram_port_pkg::LANES-1:0] byte_write_select_n,
  output logic [sram_port_pkg::DATA_W-1:0] rd_data,
  output logic rd_data_oe,
  output logic read_valid_indicator,
  output logic next_rise_neg
);
  localparam int DW = sram_port_pkg::DATA_W;
  localparam int LW = sram_port_pkg::LANE_W;
  localparam int NL = sram_port_pkg::LANES;
  localparam int LD = sram_port_pkg::LINE_D;
  localparam int WA = ADDR_W + 2;
  localparam int ENT_W = WA + DW + NL;

  typedef struct packed {
    logic [1:0] pll_sync;
    logic phase;
    sram_port_pkg::op_t last_op;
    logic [LD-1:0] rd_v;
    logic [LD-1:0][ADDR_W-1:0] rd_a;
    logic [LD-1:0] wr_v;
    logic [LD-1:0][ADDR_W-1:0] wr_a;
    logic [DW-1:0] q;
    logic oe;
    logic qv;
  } port_st_t;

  localparam port_st_t ST_RST = '{
    pll_sync: sram_port_pkg::PLL_SYNC_RST,
    phase: sram_port_pkg::PHASE_RST,
    last_op: sram_port_pkg::OP_RST,
    rd_v: '0,
    rd_a: '0,
    wr_v: '0,
    wr_a: '0,
    q: '0,
    oe: 1'b0,
    qv: 1'b0
  };

  port_st_t s_r;
  port_st_t s_nxt;
  logic [DW-1:0] mem [0:(1<<WA)-1];
  logic [WA-1:0] drain_word;
  logic [DW-1:0] drain_data;
  logic [NL-1:0] drain_mask_n;

  fifo_stream_if #(.W(ENT_W)) push_s();
  fifo_stream_if #(.W(ENT_W)) pop_s();

  // Slot numbers are three bits wide, so the line holds at most eight entries
  if (LD < sram_port_pkg::RD_LAT_PLL + sram_port_pkg::BURST - 1 || LD > 8) begin : g_line_len
    $error("burst_sram_port: delay line does not fit the read latency");
  end
  if (LD < sram_port_pkg::WR_LAT + sram_port_pkg::BURST - 1) begin : g_wr_lat
    $error("burst_sram_port: delay line does not fit the write beats");
  end
  if (sram_port_pkg::WR_LAT < 1 || sram_port_pkg::RD_LAT_LEGACY < 2) begin : g_lat_min
    $error("burst_sram_port: latency leaves no slot ahead of the first beat");
  end
  // Array depth is built with an int shift, so keep the word address under 31 bits
  if (ADDR_W < 1 || ADDR_W > 28) begin : g_addr_w
    $error("burst_sram_port: address width outside 1 to 28");
  end
  if (sram_port_pkg::BURST != 4 || NL * LW != DW) begin : g_shape
    $error("burst_sram_port: burst of four and lanes covering the word are built in");
  end

  // Finds the line slot whose age puts it on burst beats first..first+3 at the coming edge
  function automatic logic [3:0] beat_slot(input logic [LD-1:0] v, input int first);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 0; k < sram_port_pkg::BURST; k++) begin
      if (v[first + k - 1]) begin
        r = {1'b1, 3'(first + k - 1)};
      end
    end
    return r;
  endfunction

  function automatic logic [WA-1:0] word_addr(input logic [ADDR_W-1:0] a, input logic [2:0] idx,
                                              input int first);
    logic [1:0] k;
    k = 2'(int'(idx) - (first - 1));
    return WA'({a, 2'h0}) + WA'(k);
  endfunction

  // Lanes with a high select are left as stored
  function automatic logic [DW-1:0] merge_lanes(input logic [DW-1:0] old_w,
                                                input logic [DW-1:0] new_w,
                                                input logic [NL-1:0] sel_n);
    logic [DW-1:0] r;
    r = old_w;
    for (int l = 0; l < NL; l++) begin
      if (!sel_n[l]) begin
        r[l*LW +: LW] = new_w[l*LW +: LW];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic rd_ok;
    logic wr_ok;
    int lat;
    logic [3:0] rs;
    logic [3:0] vs;
    logic [3:0] ws;
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    lat = s_r.pll_sync[1] ? sram_port_pkg::RD_LAT_PLL : sram_port_pkg::RD_LAT_LEGACY;
    rs = beat_slot(s_r.rd_v, lat);
    vs = beat_slot(s_r.rd_v, lat - 1);
    ws = beat_slot(s_r.wr_v, sram_port_pkg::WR_LAT);
    s_nxt = s_r;
    push_s.valid = 1'b0;
    push_s.data = {word_addr(s_r.wr_a[ws[2:0]], ws[2:0], sram_port_pkg::WR_LAT),
                   wr_data, byte_write_select_n};
    // Nothing moves while the input clocks stand still
    if (clk_run) begin
      s_nxt.pll_sync = {s_r.pll_sync[0], pll_disable_n};
      s_nxt.phase = ~s_r.phase;
      s_nxt.rd_v = {s_r.rd_v[LD-2:0], 1'b0};
      s_nxt.rd_a = {s_r.rd_a[LD-2:0], ADDR_W'(0)};
      s_nxt.wr_v = {s_r.wr_v[LD-2:0], 1'b0};
      s_nxt.wr_a = {s_r.wr_a[LD-2:0], ADDR_W'(0)};
      if (!s_r.phase) begin
        // Port selects count only on the positive rise
        rd_ok = !read_port_select_n && s_r.last_op != sram_port_pkg::OP_READ;
        // A write needs room in the FIFO; a full FIFO refuses the start
        wr_ok = !write_port_select_n && s_r.last_op != sram_port_pkg::OP_WRITE
                && push_s.ready;
        // Read wins when both may start, so idle-to-both alternates from a read
        if (rd_ok) begin
          s_nxt.rd_v[0] = 1'b1;
          s_nxt.rd_a[0] = addr;
          s_nxt.last_op = sram_port_pkg::OP_READ;
        end else if (wr_ok) begin
          s_nxt.wr_v[0] = 1'b1;
          s_nxt.wr_a[0] = addr;
          s_nxt.last_op = sram_port_pkg::OP_WRITE;
        end else begin
          s_nxt.last_op = sram_port_pkg::OP_NONE;
        end
      end
      // Beat data is taken on both rises; deselected lanes enter the FIFO with the word and are masked only at the drain
      push_s.valid = ws[3];
      // No forwarding: a word still queued in the FIFO reads as its old value
      if (rs[3]) begin
        s_nxt.q = mem[word_addr(s_r.rd_a[rs[2:0]], rs[2:0], lat)];
      end
      // Drive stops right after the last pending beat
      s_nxt.oe = rs[3];
      s_nxt.qv = vs[3];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  write_fifo #(.W(ENT_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .clk(clk),
    .nrst(nrst),
    .in_s(push_s),
    .out_s(pop_s)
  );

  // Draining stalls with the clocks, so a long stop holds queued beats
  assign pop_s.ready = clk_run;
  assign drain_word = pop_s.data[ENT_W-1 -: WA];
  assign drain_data = pop_s.data[NL +: DW];
  assign drain_mask_n = pop_s.data[NL-1:0];

  always_ff @(posedge clk) begin
    if (pop_s.valid && pop_s.ready) begin
      mem[drain_word] <= merge_lanes(mem[drain_word], drain_data, drain_mask_n);
    end
  end

  assign rd_data = s_r.q;
  assign rd_data_oe = s_r.oe;
  assign read_valid_indicator = s_r.qv;
  assign next_rise_neg = s_r.phase;
endmodule
`default_nettype wire

// File: testbench/burst_sram_port_checker.sv
// Pin-level assertions on the burst SRAM port
`timescale 1ns/1ps
`default_nettype none
module burst_sram_port_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_run,
  input wire logic pll_disable_n,
  input wire logic read_port_select_n,
  input wire logic [sram_port_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_data_oe,
  input wire logic read_valid_indicator,
  input wire logic next_rise_neg
);
  logic prev_rd_r;
  logic [2:0] pll_r;
  logic rd_take;
  logic pll_q;
  assign rd_take = nrst && clk_run && !next_rise_neg && !read_port_select_n && !prev_rd_r;
  // Three edges of history so the design's two-flop sync has surely settled
  assign pll_q = &pll_r;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_rd_r <= 1'b0;
      pll_r <= 3'h7;
    end else begin
      pll_r <= {pll_r[1:0], pll_disable_n};
      if (clk_run && !next_rise_neg) begin
        prev_rd_r <= rd_take;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  freeze_hold_a: assert property (!clk_run |=> $stable(rd_data) && $stable(rd_data_oe)
    && $stable(read_valid_indicator) && $stable(next_rise_neg)) else $error("moved while stopped");
  rise_alt_a: assert property (clk_run |=> next_rise_neg != $past(next_rise_neg))
    else $error("rise phase did not alternate");
  rd_valid_a: assert property (rd_take && pll_q ##1 clk_run [*4] |=> read_valid_indicator)
    else $error("valid late");
  rd_lat_a: assert property (rd_take && pll_q ##1 clk_run [*5] |=> rd_data_oe
    && $past(read_valid_indicator)) else $error("read data late");
  rd_tail_a: assert property ($rose(rd_data_oe) |-> rd_data_oe [*4])
    else $error("burst cut short");
  valid_origin_a: assert property ($rose(read_valid_indicator) && pll_q |-> $past(rd_take, 5))
    else $error("valid without read");
  rd_second_a: assert property (rd_take && pll_q ##2 !read_port_select_n ##1
    (clk_run && read_port_select_n) [*7] |=> !rd_data_oe) else $error("second read taken");
  data_hold_a: assert property (!rd_data_oe |-> $stable(rd_data))
    else $error("data moved while off");
  cover property (rd_take && !pll_q);
  cover property (!clk_run && rd_data_oe);
  cover property ($fell(rd_data_oe));
endmodule
bind burst_sram_port burst_sram_port_checker u_chk (.clk, .nrst, .clk_run, .pll_disable_n,
  .read_port_select_n, .rd_data, .rd_data_oe, .read_valid_indicator, .next_rise_neg);
`default_nettype wire

// File: testbench/ctl_model.sv
// Far-side controller model that captures read beats
`timescale 1ns/1ps
`default_nettype none
module ctl_model (
  input wire logic clk,
  input wire logic clk_run,
  input wire logic rd_data_oe,
  input wire logic [sram_port_pkg::DATA_W-1:0] rd_data
);
  int cnt = 0;
  logic [sram_port_pkg::DATA_W-1:0] got[$];
  int at[$];
  // Clock parking level when stopped is not modelled, only gating
  always @(posedge clk) begin
    if (clk_run) begin
      cnt++;
      if (rd_data_oe) begin
        got.push_back(rd_data);
        at.push_back(cnt);
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the burst SRAM port logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
  logic clk = 0;
  logic nrst = 0;
  logic clk_run = 1;
  logic pll_disable_n = 1;
  logic read_port_select_n = 1;
  logic write_port_select_n = 1;
  logic [17:0] addr = 18'h0;
  logic [35:0] wr_data = 36'h0;
  logic [3:0] byte_write_select_n = 4'hF;
  logic [35:0] rd_data;
  logic rd_data_oe;
  logic read_valid_indicator;
  logic next_rise_neg;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [35:0] mem_e [int];
  always #10 clk = ~clk;
  burst_sram_port u_burst_sram_port (.clk, .nrst, .clk_run, .pll_disable_n, .read_port_select_n,
    .write_port_select_n, .addr, .wr_data, .byte_write_select_n, .rd_data, .rd_data_oe,
    .read_valid_indicator, .next_rise_neg);
  ctl_model u_ctl_model (.clk, .clk_run, .rd_data_oe, .rd_data);
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic step(int n = 1);
    repeat (n) @(negedge clk);
  endtask
  task automatic pos();
    while (next_rise_neg !== 1'b0) step();
  endtask
  task automatic beats(int a, logic [35:0] d, logic [15:0] m);
    for (int k = 0; k < 4; k++) begin
      step();
      wr_data = d + 36'(k);
      byte_write_select_n = m[4*k+:4];
      for (int l = 0; l < 4; l++) begin
        if (!m[4*k+l]) mem_e[4*a+k][9*l+:9] = wr_data[9*l+:9];
      end
    end
    step();
    // Released data lines show the inverse, never a stale copy
    wr_data = ~wr_data;
    byte_write_select_n = 4'hF;
  endtask
  task automatic wr(int a, logic [35:0] d, logic [15:0] m);
    pos();
    write_port_select_n = 1'b0;
    addr = 18'(a);
    step();
    write_port_select_n = 1'b1;
    // Released address shows the inverse, never a stale copy
    addr = ~addr;
    beats(a, d, m);
  endtask
  task automatic wait4();
    int i = 0;
    while (u_ctl_model.got.size() < 4 && i < 40) begin
      step();
      i++;
    end
  endtask
  task automatic rd(int a, int lat, bit stall);
    int t0;
    pos();
    u_ctl_model.got.delete();
    u_ctl_model.at.delete();
    t0 = u_ctl_model.cnt;
    read_port_select_n = 1'b0;
    addr = 18'(a);
    step();
    read_port_select_n = 1'b1;
    addr = ~addr;
    if (stall) begin
      step(lat + 2);
      clk_run = 1'b0;
      step(3);
      clk_run = 1'b1;
    end
    wait4();
    `CHK("latency", t0 + lat + 2, u_ctl_model.at[0])
    for (int k = 0; k < 4; k++) `CHK("rd_word", mem_e[4*a+k], u_ctl_model.got[k])
  endtask
  task automatic t_both();
    logic [35:0] old [4];
    for (int k = 0; k < 4; k++) old[k] = mem_e[12+k];
    pos();
    u_ctl_model.got.delete();
    read_port_select_n = 1'b0;
    write_port_select_n = 1'b0;
    addr = 18'h3;
    step(3);
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    addr = ~addr;
    beats(3, 36'h0_5A5A_5A50, 16'hF000);
    wait4();
    for (int k = 0; k < 4; k++) `CHK("first_read", old[k], u_ctl_model.got[k])
    rd(3, 5, 0);
  endtask
  task automatic t_dup();
    pos();
    u_ctl_model.got.delete();
    read_port_select_n = 1'b0;
    addr = 18'h3;
    step(3);
    read_port_select_n = 1'b1;
    step(16);
    `CHK("beat_count", 4, u_ctl_model.got.size())
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    step(5);
    nrst = 1'b1;
    step();
    `CHK("oe_idle", 1'b0, rd_data_oe)
    wr(3, 36'h1_2345_6780, 16'h0000);
    rd(3, 5, 0);
    wr(3, 36'hF_EDCB_A980, 16'h7BDE);
    rd(3, 5, 0);
    t_both();
    t_dup();
    pll_disable_n = 1'b0;
    step(4);
    rd(3, 3, 1);
    pll_disable_n = 1'b1;
    step(4);
    print_verdict();
  end
endmodule
`default_nettype wire
